// File: rtl/fsc_consts.vh
// Constants for the fuse system configuration loader
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH
// ************************************************************
// Fuse word field positions
// ************************************************************
`define FSC_F_CSA 0
`define FSC_F_CSB 2
`define FSC_F_OSB 4
`define FSC_F_X2 5
`define FSC_F_SUT 6
`define FSC_F_CMP 8
`define FSC_F_XRM 9
`define FSC_F_BLJ 10
`define FSC_F_OCD 11
`define FSC_F_ISP 12
`define FSC_F_SIG 13
`define FSC_F_DPS 14
`define FSC_F_LPM 15
`define FSC_FUSE_BLANK 16'hffff
`define FSC_API_WMASK 16'hc6e0
// ************************************************************
// Register byte offsets
// ************************************************************
`define FSC_OFF_FUSE 6'h00
`define FSC_OFF_APPLIED 6'h04
`define FSC_OFF_NVPROG 6'h08
`define FSC_OFF_CLKCTL 6'h0c
`define FSC_OFF_AUXCTL 6'h10
`define FSC_OFF_PM0LO 6'h14
`define FSC_OFF_PM0HI 6'h18
`define FSC_OFF_PM1LO 6'h1c
`define FSC_OFF_PM1HI 6'h20
// ************************************************************
// Reset values and encodings
// ************************************************************
`define FSC_DIV_TWO 8'h02
`define FSC_DIV_ONE 8'h01
`define FSC_CPC_COMPAT 4'hc
`define FSC_CPC_FAST 4'h1
`define FSC_SRC_HSXTAL 3'h0
`define FSC_SRC_LPXTAL 3'h1
`define FSC_SRC_EXTPRI 3'h2
`define FSC_SRC_RCA 3'h3
`define FSC_SRC_XTAL32K 3'h4
`define FSC_SRC_EXTSEC 3'h5
`define FSC_SRC_RCB 3'h6
// ************************************************************
// Start-up delays
// ************************************************************
`define FSC_CLK_MHZ 20
`define FSC_SUT0_US 1
`define FSC_SUT1_US 16
`define FSC_SUT2_US 256
`define FSC_SUT3_US 1024
`define FSC_SUT0_CYC (`FSC_SUT0_US * `FSC_CLK_MHZ)
`define FSC_SUT1_CYC (`FSC_SUT1_US * `FSC_CLK_MHZ)
`define FSC_SUT2_CYC (`FSC_SUT2_US * `FSC_CLK_MHZ)
`define FSC_SUT3_CYC (`FSC_SUT3_US * `FSC_CLK_MHZ)
`endif

// File: rtl/fsc_clk_div.v
// System clock enable divider
`default_nettype none
module fsc_clk_div (
    input wire hclk,
    input wire hresetn,
    input wire run,
    input wire [7:0] div,
    output reg clk_en_q
);
    reg [7:0] cnt_q;
    wire [7:0] last = (div == 8'h00) ? 8'h00 : div - 8'h01;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
            clk_en_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h00;
            clk_en_q <= 1'b0;
        end else if (cnt_q >= last) begin
            cnt_q <= 8'h00;
            clk_en_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            clk_en_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/fsc_port_cfg.v
// Per-pin I/O mode bits with fuse-driven default
`default_nettype none
module fsc_port_cfg #(
    parameter NPIN = 40
) (
    input wire hclk,
    input wire hresetn,
    input wire load_dflt,
    input wire dflt_tristate,
    input wire wr_m0_lo,
    input wire wr_m0_hi,
    input wire wr_m1_lo,
    input wire wr_m1_hi,
    input wire [31:0] wdata,
    output wire [NPIN-1:0] m0,
    output wire [NPIN-1:0] m1
);
    // Mode per pin {m1,m0}: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain
    genvar i;
    generate
        for (i = 0; i < NPIN; i = i + 1) begin : g_pin
            reg m0_q;
            reg m1_q;
            wire w0 = (i < 32) ? wr_m0_lo : wr_m0_hi;
            wire w1 = (i < 32) ? wr_m1_lo : wr_m1_hi;
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    m0_q <= 1'b0;
                    m1_q <= 1'b0;
                end else if (load_dflt) begin
                    m0_q <= 1'b0;
                    m1_q <= dflt_tristate;
                end else begin
                    if (w0)
                        m0_q <= wdata[i % 32];
                    if (w1)
                        m1_q <= wdata[i % 32];
                end
            end
            assign m0[i] = m0_q;
            assign m1[i] = m1_q;
        end
    endgenerate
endmodule
`default_nettype wire

// File: rtl/fsc_top.v
// Fuse store, boot-time option loader and run-time option registers
//
// How it works
// - Options sit in a store kept apart from the ordinary reset.
// - Options change only via programming; on-chip routines reach only a subset.
// - Run-time options live in separate software-writable registers.
// - Oscillator A source: fast crystal, low-power crystal, primary external, or RC.
// - Oscillator B source: 32 kHz crystal, secondary external clock, or RC.
// - Oscillator select option picks which oscillator boots the device.
// - Double-speed option sets the clock divider default: by two or undivided.
// - Start-up option picks the delay for power-on, brown-out and power-down wake.
// - Compatibility option selects twelve-clock or single-cycle CPU timing.
// - Fast mode lets instructions finish in one to four clocks.
// - Mapping option sets default access to on-chip external-data memories.
// - Bootloader option enables or blocks bootloader entry.
// - Debug access is refused unless the debug option is set.
// - Serial programming option allows or blocks in-system programming.
// - Signature option allows or blocks user signature programming.
// - Port option makes every pin input-only or quasi-bidirectional after reset.
// - Each pin takes one of four modes independently.
// - Low-power option enables power reduction features.
// - Every option-derived software bit returns to its default on any reset.
// - Fast mode makes the clock divider default to one.
//
// The register offsets and register access over AHB-Lite were decided locally.
`include "fsc_consts.vh"
`default_nettype none
module fsc_top #(
    parameter NPIN = 40,
    parameter [14:0] SUT0_CYC = `FSC_SUT0_CYC,
    parameter [14:0] SUT1_CYC = `FSC_SUT1_CYC,
    parameter [14:0] SUT2_CYC = `FSC_SUT2_CYC,
    parameter [14:0] SUT3_CYC = `FSC_SUT3_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire nv_blank_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire prog_we,
    input wire [15:0] prog_wdata,
    input wire brownout_reset_event,
    input wire power_down_wakeup,
    input wire dbg_req,
    input wire isp_req,
    input wire sig_req,
    output reg cpu_rst_n_q,
    output reg cpu_hold_q,
    output reg [2:0] sys_clk_src_q,
    output reg osc_a_en_q,
    output reg osc_b_en_q,
    output reg [7:0] sys_div_q,
    output wire sys_clk_en,
    output reg cpu_fast_q,
    output reg [3:0] cpu_cyc_clk_q,
    output reg xram_en_q,
    output reg boot_jump_en_q,
    output reg dbg_grant_q,
    output reg isp_grant_q,
    output reg sig_grant_q,
    output reg low_power_q,
    output wire [NPIN-1:0] port_m0,
    output wire [NPIN-1:0] port_m1
);
    // ************************************************************
    // Boot states
    // ************************************************************
    localparam [1:0] S_RST = 2'h0;
    localparam [1:0] S_LOAD = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;
    localparam [1:0] S_RUN = 2'h3;

    reg [15:0] fuse_q;
    reg [15:0] sh_q;
    reg [1:0] st_q;
    reg [14:0] su_cnt_q;
    reg wr_pend_q;
    reg rd_pend_q;
    reg [5:0] ap_addr_q;
    reg [31:0] rd_mux;
    reg [14:0] su_len;
    reg [7:0] div_dflt;

    // ************************************************************
    // Bus write decode
    // ************************************************************
    // Port writes lose to the reset default during the load cycle
    wire load = (st_q == S_LOAD);
    wire ap_ok = hsel & hready & htrans[1];
    wire bus_wr = wr_pend_q;
    wire wr_nv = bus_wr & (ap_addr_q == `FSC_OFF_NVPROG);
    wire wr_clk = bus_wr & (ap_addr_q == `FSC_OFF_CLKCTL);
    wire wr_aux = bus_wr & (ap_addr_q == `FSC_OFF_AUXCTL);
    wire wr_m0l = bus_wr & (ap_addr_q == `FSC_OFF_PM0LO) & ~load;
    wire wr_m0h = bus_wr & (ap_addr_q == `FSC_OFF_PM0HI) & ~load;
    wire wr_m1l = bus_wr & (ap_addr_q == `FSC_OFF_PM1LO) & ~load;
    wire wr_m1h = bus_wr & (ap_addr_q == `FSC_OFF_PM1HI) & ~load;

    // ************************************************************
    // Nonvolatile option store
    // ************************************************************
    // Only the blank strobe clears it; system reset leaves it alone
    always @(posedge hclk or negedge nv_blank_n) begin
        if (!nv_blank_n)
            fuse_q <= `FSC_FUSE_BLANK;
        else if (prog_we)
            fuse_q <= prog_wdata;
        else if (wr_nv)
            fuse_q <= (fuse_q & ~`FSC_API_WMASK) | (hwdata[15:0] & `FSC_API_WMASK);
    end

    // ************************************************************
    // Start-up delay select
    // ************************************************************
    // Copy, not the live store, so a burn mid-wait cannot stretch it
    always @* begin
        case (sh_q[`FSC_F_SUT+1:`FSC_F_SUT])
            2'h0: su_len = SUT0_CYC;
            2'h1: su_len = SUT1_CYC;
            2'h2: su_len = SUT2_CYC;
            default: su_len = SUT3_CYC;
        endcase
    end

    // ************************************************************
    // Boot sequencer
    // ************************************************************
    // Brown-out restarts the whole load; the store itself is untouched
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_RST;
            sh_q <= `FSC_FUSE_BLANK;
            su_cnt_q <= 15'h0000;
            cpu_rst_n_q <= 1'b0;
            cpu_hold_q <= 1'b1;
        end else if (brownout_reset_event) begin
            st_q <= S_LOAD;
            cpu_rst_n_q <= 1'b0;
            cpu_hold_q <= 1'b1;
        end else begin
            case (st_q)
                S_RST: begin
                    st_q <= S_LOAD;
                end
                S_LOAD: begin
                    sh_q <= fuse_q;
                    su_cnt_q <= 15'h0000;
                    st_q <= S_WAIT;
                end
                S_WAIT: begin
                    // Delay picked from the freshly loaded copy
                    if (su_cnt_q >= su_len - 15'h0001) begin
                        st_q <= S_RUN;
                        cpu_rst_n_q <= 1'b1;
                        cpu_hold_q <= 1'b0;
                    end else begin
                        su_cnt_q <= su_cnt_q + 15'h0001;
                    end
                end
                S_RUN: begin
                    // Wake from power-down keeps the CPU state, only stalls it
                    if (power_down_wakeup) begin
                        st_q <= S_WAIT;
                        su_cnt_q <= 15'h0000;
                        cpu_hold_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= S_RST;
                end
            endcase
        end
    end

    // ************************************************************
    // Option-driven outputs
    // ************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_clk_src_q <= `FSC_SRC_HSXTAL;
            osc_a_en_q <= 1'b1;
            osc_b_en_q <= 1'b0;
            cpu_fast_q <= 1'b0;
            cpu_cyc_clk_q <= `FSC_CPC_COMPAT;
            boot_jump_en_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            osc_b_en_q <= sh_q[`FSC_F_OSB];
            osc_a_en_q <= ~sh_q[`FSC_F_OSB];
            if (sh_q[`FSC_F_OSB]) begin
                case (sh_q[`FSC_F_CSB+1:`FSC_F_CSB])
                    2'h0: sys_clk_src_q <= `FSC_SRC_XTAL32K;
                    2'h1: sys_clk_src_q <= `FSC_SRC_EXTSEC;
                    default: sys_clk_src_q <= `FSC_SRC_RCB;
                endcase
            end else begin
                case (sh_q[`FSC_F_CSA+1:`FSC_F_CSA])
                    2'h0: sys_clk_src_q <= `FSC_SRC_HSXTAL;
                    2'h1: sys_clk_src_q <= `FSC_SRC_LPXTAL;
                    2'h2: sys_clk_src_q <= `FSC_SRC_EXTPRI;
                    default: sys_clk_src_q <= `FSC_SRC_RCA;
                endcase
            end
            // Blank compatibility fuse means classic timing
            cpu_fast_q <= ~sh_q[`FSC_F_CMP];
            cpu_cyc_clk_q <= sh_q[`FSC_F_CMP] ? `FSC_CPC_COMPAT : `FSC_CPC_FAST;
            boot_jump_en_q <= sh_q[`FSC_F_BLJ];
            low_power_q <= sh_q[`FSC_F_LPM];
        end
    end

    // ************************************************************
    // Debug and programming access gates
    // ************************************************************
    // A request whose option is clear is refused, not held over
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_grant_q <= 1'b0;
            isp_grant_q <= 1'b0;
            sig_grant_q <= 1'b0;
        end else begin
            dbg_grant_q <= dbg_req & sh_q[`FSC_F_OCD];
            isp_grant_q <= isp_req & sh_q[`FSC_F_ISP];
            sig_grant_q <= sig_req & sh_q[`FSC_F_SIG];
        end
    end

    // ************************************************************
    // Divider reset default
    // ************************************************************
    // Fast timing wins over the double-speed bit
    always @* begin
        if (!fuse_q[`FSC_F_CMP])
            div_dflt = `FSC_DIV_ONE;
        else if (fuse_q[`FSC_F_X2])
            div_dflt = `FSC_DIV_ONE;
        else
            div_dflt = `FSC_DIV_TWO;
    end

    // ************************************************************
    // Run-time option registers
    // ************************************************************
    // Load from the live store beats a software write in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_div_q <= `FSC_DIV_TWO;
            xram_en_q <= 1'b0;
        end else if (load) begin
            sys_div_q <= div_dflt;
            xram_en_q <= fuse_q[`FSC_F_XRM];
        end else begin
            if (wr_clk)
                sys_div_q <= hwdata[7:0];
            if (wr_aux)
                xram_en_q <= hwdata[0];
        end
    end

    // ************************************************************
    // System clock enable
    // ************************************************************
    // Enables stop while the CPU is held so a wake starts on a clean count
    fsc_clk_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(~cpu_hold_q),
        .div(sys_div_q),
        .clk_en_q(sys_clk_en)
    );

    // ************************************************************
    // Pin mode bits
    // ************************************************************
    fsc_port_cfg #(
        .NPIN(NPIN)
    ) u_port (
        .hclk(hclk),
        .hresetn(hresetn),
        .load_dflt(load),
        .dflt_tristate(~fuse_q[`FSC_F_DPS]),
        .wr_m0_lo(wr_m0l),
        .wr_m0_hi(wr_m0h),
        .wr_m1_lo(wr_m1l),
        .wr_m1_hi(wr_m1h),
        .wdata(hwdata),
        .m0(port_m0),
        .m1(port_m1)
    );

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    // Reads take one wait state so a write just before is seen
    always @* begin
        rd_mux = 32'h00000000;
        case (ap_addr_q)
            `FSC_OFF_FUSE: rd_mux[15:0] = fuse_q;
            `FSC_OFF_APPLIED: rd_mux = {14'h0000, st_q, sh_q};
            `FSC_OFF_CLKCTL: rd_mux[7:0] = sys_div_q;
            `FSC_OFF_AUXCTL: rd_mux[0] = xram_en_q;
            `FSC_OFF_PM0LO: rd_mux = port_m0[31:0];
            `FSC_OFF_PM0HI: rd_mux[NPIN-33:0] = port_m0[NPIN-1:32];
            `FSC_OFF_PM1LO: rd_mux = port_m1[31:0];
            `FSC_OFF_PM1HI: rd_mux[NPIN-33:0] = port_m1[NPIN-1:32];
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Error response never raised: every access, mapped or not, is OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            ap_addr_q <= 6'h00;
        end else begin
            wr_pend_q <= ap_ok & hwrite;
            if (ap_ok) begin
                ap_addr_q <= {haddr[5:2], 2'b00};
                if (!hwrite) begin
                    rd_pend_q <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end else if (rd_pend_q) begin
                hrdata <= rd_mux;
                rd_pend_q <= 1'b0;
                hreadyout <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/fsc_chk.sv
// Checker on the option loader top-level ports
`default_nettype none
module fsc_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic dbg_req,
    input wire logic isp_req,
    input wire logic sig_req,
    input wire logic dbg_grant_q,
    input wire logic isp_grant_q,
    input wire logic sig_grant_q,
    input wire logic osc_a_en_q,
    input wire logic osc_b_en_q,
    input wire logic [2:0] sys_clk_src_q,
    input wire logic cpu_rst_n_q,
    input wire logic cpu_hold_q,
    input wire logic cpu_fast_q,
    input wire logic [3:0] cpu_cyc_clk_q,
    input wire logic [7:0] sys_div_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic take = hsel && hready && htrans[1];
    // ************************************************************
    // Bus and option relations
    // ************************************************************
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    dbg_gate_a: assert property (dbg_grant_q |-> $past(dbg_req))
        else $error("debug granted without request");
    isp_gate_a: assert property (isp_grant_q |-> $past(isp_req))
        else $error("serial programming granted without request");
    sig_gate_a: assert property (sig_grant_q |-> $past(sig_req))
        else $error("signature programming granted without request");
    osc_onehot_a: assert property (osc_a_en_q ^ osc_b_en_q)
        else $error("oscillator enables not one-hot");
    src_a_range_a: assert property (osc_a_en_q |-> sys_clk_src_q <= 3'h3)
        else $error("oscillator A source out of range");
    src_b_range_a: assert property (osc_b_en_q |-> sys_clk_src_q inside {[3'h4:3'h6]})
        else $error("oscillator B source out of range");
    cpu_held_a: assert property (!cpu_rst_n_q |-> cpu_hold_q)
        else $error("cpu released while in reset");
    cyc_mode_a: assert property (cpu_cyc_clk_q == (cpu_fast_q ? 4'h1 : 4'hc))
        else $error("clocks per cycle disagree with mode");
    fast_div_a: assert property ($rose(cpu_rst_n_q) && cpu_fast_q |-> sys_div_q == 8'h01)
        else $error("fast mode divider default not one");
endmodule
`default_nettype wire

// File: dv/fsc_prog_model.sv
// External programmer model driving the fuse write pins
`default_nettype none
module fsc_prog_model (
    input wire logic hclk,
    output logic prog_we,
    output logic [15:0] prog_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        prog_we = 1'b0;
        prog_wdata = 16'h0000;
    end
    // Whole word per strobe; data is junk outside it so nothing leans on it
    task automatic burn(input logic [15:0] w);
        @(posedge hclk);
        prog_we <= 1'b1;
        prog_wdata <= w;
        @(posedge hclk);
        prog_we <= 1'b0;
        prog_wdata <= ~w;
    endtask
endmodule
`default_nettype wire

// File: dv/fsc_top_test.sv
// Testbench for the fuse option loader
`default_nettype none
module fsc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [15:0] f; logic [2:0] s; logic [7:0] d;} fsc_row_t;
    logic hclk = 1'b0, hresetn, nv_blank_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, sys_clk_src_q;
    logic prog_we, brownout_reset_event, power_down_wakeup, dbg_req, isp_req, sig_req;
    logic [15:0] prog_wdata;
    logic cpu_rst_n_q, cpu_hold_q, osc_a_en_q, osc_b_en_q, sys_clk_en, cpu_fast_q;
    logic xram_en_q, boot_jump_en_q, dbg_grant_q, isp_grant_q, sig_grant_q, low_power_q;
    logic [7:0] sys_div_q;
    logic [3:0] cpu_cyc_clk_q;
    logic [39:0] port_m0, port_m1;
    int fails = 0;
    int compares = 0;
    int c;
    logic [15:0] f;
    fsc_row_t rows [7] = '{{16'h0900, 3'h0, 8'h02}, {16'h1361, 3'h1, 8'h01},
        {16'h6082, 3'h2, 8'h01}, {16'h85c3, 3'h3, 8'h02}, {16'h0110, 3'h4, 8'h02},
        {16'h0134, 3'h5, 8'h01}, {16'h3e18, 3'h6, 8'h01}};
    assign hready = hreadyout;
    always #25 hclk = ~hclk;
    fsc_top #(.NPIN(40), .SUT0_CYC(15'd4), .SUT1_CYC(15'd8), .SUT2_CYC(15'd12),
        .SUT3_CYC(15'd16)) u_fsc_top (.hclk, .hresetn, .nv_blank_n, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
        .prog_we, .prog_wdata, .brownout_reset_event, .power_down_wakeup, .dbg_req,
        .isp_req, .sig_req, .cpu_rst_n_q, .cpu_hold_q, .sys_clk_src_q, .osc_a_en_q,
        .osc_b_en_q, .sys_div_q, .sys_clk_en, .cpu_fast_q, .cpu_cyc_clk_q, .xram_en_q,
        .boot_jump_en_q, .dbg_grant_q, .isp_grant_q, .sig_grant_q, .low_power_q,
        .port_m0, .port_m1);
    fsc_prog_model u_fsc_prog_model (.hclk, .prog_we, .prog_wdata);
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {26'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
        @(negedge hclk);
    endtask
    task automatic rdchk(input string n, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(n, e, r);
    endtask
    // Hard restart pulses the system reset, otherwise a brown-out event
    task automatic boot(input logic hard, output int n);
        n = 0;
        @(posedge hclk);
        if (hard) hresetn <= 1'b0;
        else brownout_reset_event <= 1'b1;
        @(posedge hclk);
        hresetn <= 1'b1;
        brownout_reset_event <= 1'b0;
        while (cpu_rst_n_q !== 1'b0) @(posedge hclk);
        while (cpu_rst_n_q !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        #250000;
        fails++;
        give_verdict;
    end
    initial begin
        {hresetn, nv_blank_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {brownout_reset_event, power_down_wakeup} = 2'b00;
        {dbg_req, isp_req, sig_req} = 3'b111;
        repeat (16) @(posedge hclk);
        chk("reset cpu", 0, {cpu_rst_n_q, cpu_hold_q, hreadyout} ^ 3'b011);
        chk("reset div", 8'h02, sys_div_q);
        hresetn <= 1'b1;
        nv_blank_n <= 1'b1;
        foreach (rows[i]) begin
            f = rows[i].f;
            u_fsc_prog_model.burn(f);
            boot(1'b0, c);
            chk("delay", 1, c > (f[7:6] + 1) * 4 && c <= (f[7:6] + 1) * 4 + 4);
            chk("source", rows[i].s, sys_clk_src_q);
            chk("osc", {f[4], ~f[4]}, {osc_b_en_q, osc_a_en_q});
            chk("divider", rows[i].d, sys_div_q);
            chk("mode", {~f[8], f[8] ? 4'hc : 4'h1}, {cpu_fast_q, cpu_cyc_clk_q});
            chk("xram", f[9], xram_en_q);
            chk("bootjump", f[10], boot_jump_en_q);
            chk("grants", f[13:11], {sig_grant_q, isp_grant_q, dbg_grant_q});
            chk("lowpower", f[15], low_power_q);
            chk("port m1", {40{~f[14]}}, port_m1);
            chk("port m0", 40'h0, port_m0);
            rdchk("fuse", 6'h00, {16'h0, f});
        end
        {dbg_req, isp_req, sig_req} <= 3'b101;
        repeat (2) @(posedge hclk);
        chk("grants drop", 3'b101, {sig_grant_q, isp_grant_q, dbg_grant_q});
        // On-chip path may only touch the writable subset
        u_fsc_prog_model.burn(16'h0100);
        wr(6'h08, 32'h0000ffff);
        wr(6'h00, 32'h0);
        rdchk("fuse masked", 6'h00, 32'h0000c7e0);
        rdchk("unmapped", 6'h3c, 32'h0);
        wr(6'h0c, 32'h05);
        rdchk("clkctl", 6'h0c, 32'h05);
        chk("div run", 8'h05, sys_div_q);
        c = 0;
        repeat (50) @(posedge hclk) c += sys_clk_en;
        chk("clock enables", 10, c);
        wr(6'h10, 32'h0);
        chk("xram run", 0, xram_en_q);
        wr(6'h14, 32'hffffffff);
        wr(6'h18, 32'hff);
        wr(6'h1c, 32'h0);
        wr(6'h20, 32'h0);
        chk("pins push", {40'h0, 24'hffffff}, {port_m1, port_m0[39:16]});
        chk("pins lo", 16'hffff, port_m0[15:0]);
        rdchk("pm0 hi", 6'h18, 32'h000000ff);
        boot(1'b1, c);
        rdchk("fuse kept", 6'h00, 32'h0000c7e0);
        rdchk("applied", 6'h04, 32'h0003c7e0);
        chk("div default", 8'h01, sys_div_q);
        rdchk("clkctl default", 6'h0c, 32'h01);
        chk("xram default", 1, xram_en_q);
        chk("pins default", 80'h0, {port_m1, port_m0});
        @(posedge hclk);
        power_down_wakeup <= 1'b1;
        @(posedge hclk);
        power_down_wakeup <= 1'b0;
        while (cpu_hold_q !== 1'b1) @(posedge hclk);
        c = 0;
        while (cpu_hold_q !== 1'b0) begin
            chk("wake no reset", 1, cpu_rst_n_q);
            @(posedge hclk);
            c++;
        end
        chk("wake delay", 1, c >= 16 && c <= 20);
        give_verdict;
    end
endmodule
bind fsc_top fsc_chk u_fsc_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .dbg_req, .isp_req, .sig_req, .dbg_grant_q, .isp_grant_q,
    .sig_grant_q, .osc_a_en_q, .osc_b_en_q, .sys_clk_src_q, .cpu_rst_n_q, .cpu_hold_q,
    .cpu_fast_q, .cpu_cyc_clk_q, .sys_div_q);
`default_nettype wire
